/* File: verilog/port_pin_config.sv */
// Port pin configuration block with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module port_pin_config import port_cfg_pkg::*; (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Pins
    input wire logic [NPIN-1:0] I_PIN_IN,
    output logic [NPIN-1:0] O_PIN_OUT,
    output logic [NPIN-1:0] O_PIN_OE,
    output logic [NPIN-1:0] O_PULLUP_EN,
    output logic [NPIN-1:0] O_TTL_SEL,
    output logic [NPIN-1:0] O_THRESH_SEL,
    output logic [NPIN-1:0] O_SLEW_SLOW,
    output logic [NPIN-1:0] O_ANALOG_SEL,
    // Peripheral functions and standby status
    input wire logic [NFUNC-1:0] I_PERIPH_OUT,
    input wire logic [NFUNC-1:0] I_PERIPH_OE,
    output logic [NFUNC-1:0] O_PERIPH_IN,
    input wire logic I_LOW_POWER_STATE_A,
    input wire logic I_STOP_STATE
);
    // ==========================================================
    // Reset release
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // ==========================================================
    // Bus slave
    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_fire;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    reg_kind_t wr_kind;
    reg_kind_t rd_kind;
    logic [2:0] wr_port;
    logic [2:0] rd_port;

    axil_reg_slave u_slave (
        .i_clock(I_CLOCK),
        .i_reset_n(rst_n),
        .i_awaddr(I_AWADDR),
        .i_awvalid(I_AWVALID),
        .o_awready(O_AWREADY),
        .i_wdata(I_WDATA),
        .i_wstrb(I_WSTRB),
        .i_wvalid(I_WVALID),
        .o_wready(O_WREADY),
        .o_bresp(O_BRESP),
        .o_bvalid(O_BVALID),
        .i_bready(I_BREADY),
        .i_araddr(I_ARADDR),
        .i_arvalid(I_ARVALID),
        .o_arready(O_ARREADY),
        .o_rdata(O_RDATA),
        .o_rresp(O_RRESP),
        .o_rvalid(O_RVALID),
        .i_rready(I_RREADY),
        .o_wr_fire(wr_fire),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb),
        .i_wr_err(wr_kind == K_NONE),
        .o_rd_fire(rd_fire),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_err(rd_kind == K_NONE)
    );

    assign wr_kind = decode_kind(wr_addr);
    assign rd_kind = decode_kind(rd_addr);
    assign wr_port = wr_addr[4:2];
    assign rd_port = rd_addr[4:2];

    // ==========================================================
    // Configuration registers
    logic [NPORT-1:0][PORT_W-1:0] latch;
    logic [NPORT-1:0][PORT_W-1:0] dir;
    logic [NPORT-1:0][PORT_W-1:0] pull;
    logic [NPORT-1:0][PORT_W-1:0] inbuf;
    logic [NPORT-1:0][PORT_W-1:0] odrv;
    logic [NPORT-1:0][PORT_W-1:0] anlg;
    logic [NPORT-1:0][PORT_W-1:0] thr;
    logic [NPORT-1:0][PORT_W-1:0] slew;
    logic [7:0] redirect;
    logic [7:0] conv;
    logic [7:0] snz_ctrl;
    logic [7:0] rb_ctrl;
    logic [7:0] stop_ctrl;
    logic wr_lane;

    assign wr_lane = wr_fire & wr_strb[0];

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            latch <= '0;
            dir <= {NPORT{RST_DIR}};
            pull <= '0;
            pull[PULLUP_PORT] <= RST_PULLUP_P4;
            inbuf <= '0;
            odrv <= '0;
            anlg <= '0;
            thr <= '0;
            slew <= '0;
        end else if (wr_lane) begin
            case (wr_kind)
                K_DATA: latch[wr_port] <= wr_data[7:0];
                K_DIR: dir[wr_port] <= wr_data[7:0];
                K_PULLUP: pull[wr_port] <= wr_data[7:0];
                K_INBUF: inbuf[wr_port] <= wr_data[7:0];
                K_OUTDRV: odrv[wr_port] <= wr_data[7:0];
                K_ANALOG: anlg[wr_port] <= wr_data[7:0];
                K_THRESH: thr[wr_port] <= wr_data[7:0];
                K_SLEW: slew[wr_port] <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            redirect <= RST_ZERO;
            conv <= RST_ZERO;
            snz_ctrl <= RST_ZERO;
            rb_ctrl <= RST_ZERO;
            stop_ctrl <= RST_ZERO;
        end else if (wr_lane) begin
            case (wr_kind)
                K_REDIRECT: redirect <= wr_data[7:0];
                K_CONV: conv <= wr_data[7:0];
                K_LOW_POWER_STATE_A: snz_ctrl <= wr_data[7:0];
                K_READBACK: rb_ctrl <= wr_data[7:0];
                K_STOP: stop_ctrl <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Analog assignment and pin routing
    logic [NPIN-1:0] analog_pin;
    logic [NPIN-1:0] ovr_en;
    logic [NPIN-1:0] ovr_val;

    assign analog_pin = anlg | (64'(conv) << (ANALOG_PORT * PORT_W));

    // Later sources win: peripheral, then low_power_state_a, then stop status
    always_comb begin
        logic [5:0] idx;
        idx = '0;
        ovr_en = '0;
        ovr_val = '0;
        for (int i = 0; i < NFUNC; i++) begin
            idx = redirect[i] ? ALT_PIN[i] : PRI_PIN[i];
            if (I_PERIPH_OE[i]) begin
                ovr_en[idx] = 1'b1;
                ovr_val[idx] = I_PERIPH_OUT[i];
            end
        end
        if (snz_ctrl[0]) begin
            idx = SNZ_PIN[snz_ctrl[2:1]];
            ovr_en[idx] = 1'b1;
            ovr_val[idx] = I_LOW_POWER_STATE_A;
        end
        if (stop_ctrl[0]) begin
            ovr_en[STOP_PIN] = 1'b1;
            ovr_val[STOP_PIN] = I_STOP_STATE;
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_PERIPH_IN <= '0;
        end else begin
            for (int i = 0; i < NFUNC; i++) begin
                O_PERIPH_IN[i] <= I_PIN_IN[redirect[i] ? ALT_PIN[i] : PRI_PIN[i]];
            end
        end
    end

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        port_pin_cell u_cell (
            .i_clock(I_CLOCK),
            .i_reset_n(rst_n),
            .i_dir(dir[p]),
            .i_latch(latch[p]),
            .i_odrain(odrv[p]),
            .i_analog(analog_pin[p*PORT_W +: PORT_W]),
            .i_pullup(pull[p]),
            .i_ovr_en(ovr_en[p*PORT_W +: PORT_W]),
            .i_ovr_val(ovr_val[p*PORT_W +: PORT_W]),
            .o_out(O_PIN_OUT[p*PORT_W +: PORT_W]),
            .o_oe(O_PIN_OE[p*PORT_W +: PORT_W]),
            .o_pullup(O_PULLUP_EN[p*PORT_W +: PORT_W])
        );
    end

    assign O_TTL_SEL = inbuf;
    assign O_THRESH_SEL = thr;
    assign O_SLEW_SLOW = slew;

    // Analog flag registered so the output comes from a flip-flop
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_ANALOG_SEL <= '0;
        end else begin
            O_ANALOG_SEL <= analog_pin;
        end
    end

    // ==========================================================
    // Read data
    logic [7:0] pin_lvl;
    logic [7:0] pin_ana;

    assign pin_lvl = I_PIN_IN[{rd_port, 3'b000} +: PORT_W];
    assign pin_ana = analog_pin[{rd_port, 3'b000} +: PORT_W];

    always_comb begin
        rd_data = '0;
        case (rd_kind)
            K_DATA: begin
                for (int b = 0; b < PORT_W; b++) begin
                    if (pin_ana[b]) begin
                        rd_data[b] = 1'b0;
                    end else if (dir[rd_port][b] || rb_ctrl[0]) begin
                        rd_data[b] = pin_lvl[b];
                    end else begin
                        rd_data[b] = latch[rd_port][b];
                    end
                end
            end
            K_DIR: rd_data[7:0] = dir[rd_port];
            K_PULLUP: rd_data[7:0] = pull[rd_port];
            K_INBUF: rd_data[7:0] = inbuf[rd_port];
            K_OUTDRV: rd_data[7:0] = odrv[rd_port];
            K_ANALOG: rd_data[7:0] = anlg[rd_port];
            K_THRESH: rd_data[7:0] = thr[rd_port];
            K_SLEW: rd_data[7:0] = slew[rd_port];
            K_REDIRECT: rd_data[7:0] = redirect;
            K_CONV: rd_data[7:0] = conv;
            K_LOW_POWER_STATE_A: rd_data[7:0] = snz_ctrl;
            K_READBACK: rd_data[7:0] = rb_ctrl;
            K_STOP: rd_data[7:0] = stop_ctrl;
            default: rd_data = '0;
        endcase
    end

    // ==========================================================
    // Checks
    logic rd_p0_data;

    assign rd_p0_data = rd_fire && (rd_addr == BASE_DATA);

    dir_reset_a: assert property (@(posedge I_CLOCK)
        $rose(rst_n) |-> (dir == {NPORT{RST_DIR}}) && (O_PIN_OE == '0))
        else $error("Pins not inputs after reset");

    pullup_reset_a: assert property (@(posedge I_CLOCK)
        $rose(rst_n) |-> pull[PULLUP_PORT][0] ##1 O_PULLUP_EN[PULLUP_PORT*PORT_W])
        else $error("Port 4 bit 0 pull-up not on after reset");

    input_no_drive_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        dir[0][0] |=> !O_PIN_OE[0])
        else $error("Input pin is driven");

    output_latch_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        !dir[0][0] && !analog_pin[0] && !odrv[0][0] && !ovr_en[0]
        |=> O_PIN_OE[0] && (O_PIN_OUT[0] == $past(latch[0][0])))
        else $error("Output pin not driven from latch");

    read_input_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        rd_p0_data && dir[0][0] && !analog_pin[0] |=> O_RVALID && O_RDATA[0] == $past(I_PIN_IN[0]))
        else $error("Input read not pin level");

    read_pin_out_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        rd_p0_data && !dir[0][1] && rb_ctrl[0] && !analog_pin[1]
        |=> O_RDATA[1] == $past(I_PIN_IN[1]))
        else $error("Readback select did not return pin level");

    read_latch_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        rd_p0_data && !dir[0][2] && !rb_ctrl[0] && !analog_pin[2]
        |=> O_RDATA[2] == $past(latch[0][2]))
        else $error("Output read not latch value");

    open_drain_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        odrv[0][3] && latch[0][3] && !ovr_en[3] |=> !O_PIN_OE[3] && !O_PIN_OUT[3])
        else $error("Open drain drove high");

    analog_off_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        analog_pin[4] |=> !O_PIN_OE[4] && O_ANALOG_SEL[4])
        else $error("Analog pin still digital");

    stop_status_a: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        stop_ctrl[0] && !dir[STOP_PIN[5:3]][STOP_PIN[2:0]] && !analog_pin[STOP_PIN]
        && !odrv[STOP_PIN[5:3]][STOP_PIN[2:0]]
        |=> O_PIN_OE[STOP_PIN] && O_PIN_OUT[STOP_PIN] == $past(I_STOP_STATE))
        else $error("Stop status not on its pin");
endmodule
`default_nettype wire

/* File: pkg/port_cfg_pkg.sv */
// Constants, register map and decode helpers for the port pin configuration block
package port_cfg_pkg;

    // ==========================================================
    // Sizes
    localparam int NPORT = 8;
    localparam int PORT_W = 8;
    localparam int NPIN = 64;
    localparam int ADDR_W = 12;
    localparam int NFUNC = 4;

    // ==========================================================
    // Register map, per-port banks step 4 bytes per port
    localparam logic [ADDR_W-1:0] BASE_DATA = 12'h000;
    localparam logic [ADDR_W-1:0] BASE_DIR = 12'h020;
    localparam logic [ADDR_W-1:0] BASE_PULLUP = 12'h040;
    localparam logic [ADDR_W-1:0] BASE_INBUF = 12'h060;
    localparam logic [ADDR_W-1:0] BASE_OUTDRV = 12'h080;
    localparam logic [ADDR_W-1:0] BASE_ANALOG = 12'h0A0;
    localparam logic [ADDR_W-1:0] BASE_THRESH = 12'h0C0;
    localparam logic [ADDR_W-1:0] BASE_SLEW = 12'h0E0;
    localparam logic [ADDR_W-1:0] OFF_REDIRECT = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_CONV = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_LOW_POWER_STATE_A = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_READBACK = 12'h10C;
    localparam logic [ADDR_W-1:0] OFF_STOP = 12'h110;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PULLUP_P4 = 8'h01;
    localparam int PULLUP_PORT = 4;
    localparam int ANALOG_PORT = 7;

    // ==========================================================
    // Pin routing tables (flat pin index = port * 8 + bit)
    localparam logic [5:0] PRI_PIN [NFUNC] = '{6'h08, 6'h09, 6'h10, 6'h11};
    localparam logic [5:0] ALT_PIN [NFUNC] = '{6'h28, 6'h29, 6'h30, 6'h31};
    localparam logic [5:0] SNZ_PIN [4] = '{6'h18, 6'h19, 6'h1A, 6'h1B};
    localparam logic [5:0] STOP_PIN = 6'h20;

    // ==========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        K_DATA, K_DIR, K_PULLUP, K_INBUF, K_OUTDRV, K_ANALOG, K_THRESH, K_SLEW,
        K_REDIRECT, K_CONV, K_LOW_POWER_STATE_A, K_READBACK, K_STOP, K_NONE
    } reg_kind_t;

    // Address to register kind; unaligned or unknown is K_NONE
    function automatic reg_kind_t decode_kind(input logic [ADDR_W-1:0] addr);
        reg_kind_t k;
        k = K_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[ADDR_W-1:5])
                BASE_DATA[ADDR_W-1:5]: k = K_DATA;
                BASE_DIR[ADDR_W-1:5]: k = K_DIR;
                BASE_PULLUP[ADDR_W-1:5]: k = K_PULLUP;
                BASE_INBUF[ADDR_W-1:5]: k = K_INBUF;
                BASE_OUTDRV[ADDR_W-1:5]: k = K_OUTDRV;
                BASE_ANALOG[ADDR_W-1:5]: k = K_ANALOG;
                BASE_THRESH[ADDR_W-1:5]: k = K_THRESH;
                BASE_SLEW[ADDR_W-1:5]: k = K_SLEW;
                default: begin
                    case (addr)
                        OFF_REDIRECT: k = K_REDIRECT;
                        OFF_CONV: k = K_CONV;
                        OFF_LOW_POWER_STATE_A: k = K_LOW_POWER_STATE_A;
                        OFF_READBACK: k = K_READBACK;
                        OFF_STOP: k = K_STOP;
                        default: k = K_NONE;
                    endcase
                end
            endcase
        end
        return k;
    endfunction

endpackage

/* File: verilog/axil_reg_slave.sv */
// AXI4-Lite slave front end producing single-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave import port_cfg_pkg::*; (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Write address and data
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // Write response
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // Read channels
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Register side
    output logic o_wr_fire,
    output logic [ADDR_W-1:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic [3:0] o_wr_strb,
    input wire logic i_wr_err,
    output logic o_rd_fire,
    output logic [ADDR_W-1:0] o_rd_addr,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_err
);
    logic aw_full;
    logic w_full;

    assign o_wr_fire = aw_full & w_full & ~o_bvalid;
    assign o_rd_fire = i_arvalid & o_arready;
    assign o_rd_addr = i_araddr;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_awready <= 1'b1;
            aw_full <= 1'b0;
            o_wr_addr <= '0;
        end else begin
            if (o_awready && i_awvalid) begin
                o_awready <= 1'b0;
                aw_full <= 1'b1;
                o_wr_addr <= i_awaddr;
            end else if (o_wr_fire) begin
                aw_full <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                o_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wready <= 1'b1;
            w_full <= 1'b0;
            o_wr_data <= '0;
            o_wr_strb <= '0;
        end else begin
            if (o_wready && i_wvalid) begin
                o_wready <= 1'b0;
                w_full <= 1'b1;
                o_wr_data <= i_wdata;
                o_wr_strb <= i_wstrb;
            end else if (o_wr_fire) begin
                w_full <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (o_wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= i_wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end else if (o_rd_fire) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= i_rd_data;
            o_rresp <= i_rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (o_rvalid && i_rready) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/port_pin_cell.sv */
// Registered drive logic for the eight pins of one port
`timescale 1ns/1ps
`default_nettype none
module port_pin_cell import port_cfg_pkg::*; (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Configuration
    input wire logic [PORT_W-1:0] i_dir,
    input wire logic [PORT_W-1:0] i_latch,
    input wire logic [PORT_W-1:0] i_odrain,
    input wire logic [PORT_W-1:0] i_analog,
    input wire logic [PORT_W-1:0] i_pullup,
    input wire logic [PORT_W-1:0] i_ovr_en,
    input wire logic [PORT_W-1:0] i_ovr_val,
    // Pin drive
    output logic [PORT_W-1:0] o_out,
    output logic [PORT_W-1:0] o_oe,
    output logic [PORT_W-1:0] o_pullup
);
    logic [PORT_W-1:0] val;

    // Peripheral or status function takes the pin over the latch
    assign val = (i_ovr_en & i_ovr_val) | (~i_ovr_en & i_latch);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_out <= '0;
            o_oe <= '0;
            o_pullup <= '0;
        end else begin
            // Open drain never drives high, it releases the pin instead
            o_oe <= ~i_dir & ~i_analog & ~(i_odrain & val);
            o_out <= val & ~i_odrain;
            o_pullup <= i_pullup & ~i_analog;
        end
    end
endmodule
`default_nettype wire

/* File: verification/pin_board_model.sv */
// Board circuitry on the pins: external drivers, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module pin_board_model import port_cfg_pkg::*; (
    // Clock
    input wire logic i_clock,
    // Device drive
    input wire logic [NPIN-1:0] i_out,
    input wire logic [NPIN-1:0] i_oe,
    input wire logic [NPIN-1:0] i_pullup,
    // Board drive
    input wire logic [NPIN-1:0] i_ext,
    input wire logic [NPIN-1:0] i_ext_en,
    // Resolved level
    output logic [NPIN-1:0] o_level
);
    logic [NPIN-1:0] wobble = '0;
    // Undriven lines change each cycle so no stale level passes
    always_ff @(posedge i_clock) wobble <= ~wobble;
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            if (i_oe[p]) o_level[p] = i_out[p];
            else if (i_ext_en[p]) o_level[p] = i_ext[p];
            else if (i_pullup[p]) o_level[p] = 1'h1;
            else o_level[p] = wobble[p];
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_port_pin_config.sv */
// Self-checking bench for the port pin configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_config import port_cfg_pkg::*;;
    logic I_CLOCK = 0, I_RESET_N = 0, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
    logic I_ARVALID = 0, I_RREADY = 0, I_LOW_POWER_STATE_A = 0, I_STOP_STATE = 0;
    logic [11:0] I_AWADDR = '0, I_ARADDR = '0;
    logic [31:0] I_WDATA = '0, O_RDATA;
    logic [3:0] I_WSTRB = 4'hF, I_PERIPH_OUT = '0, I_PERIPH_OE = '0, O_PERIPH_IN;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    logic [1:0] O_BRESP, O_RRESP;
    logic [NPIN-1:0] I_PIN_IN, O_PIN_OUT, O_PIN_OE, O_PULLUP_EN, O_TTL_SEL;
    logic [NPIN-1:0] O_THRESH_SEL, O_SLEW_SLOW, O_ANALOG_SEL, ext = '0, ext_en = '1, got;
    int bad_count = 0, checked = 0, cycles = 0;
    port_pin_config u_port_pin_config (.*);
    pin_board_model u_pin_board_model (.i_clock(I_CLOCK), .i_out(O_PIN_OUT),
        .i_oe(O_PIN_OE), .i_pullup(O_PULLUP_EN), .i_ext(ext), .i_ext_en(ext_en),
        .o_level(I_PIN_IN));
    always #12.5 I_CLOCK = ~I_CLOCK;
    always @(posedge I_CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, ta, tw, v;
        pa = 1;
        pw = 1;
        I_AWADDR <= a;
        I_WDATA <= d;
        I_AWVALID <= 1;
        I_WVALID <= 1;
        while (pa | pw) begin
            @(negedge I_CLOCK);
            ta = pa & O_AWREADY;
            tw = pw & O_WREADY;
            @(posedge I_CLOCK);
            if (ta) begin I_AWVALID <= 0; pa = 0; end
            if (tw) begin I_WVALID <= 0; pw = 0; end
        end
        I_BREADY <= 1;
        do begin @(negedge I_CLOCK); v = O_BVALID; r = O_BRESP; @(posedge I_CLOCK); end
        while (!v);
        I_BREADY <= 0;
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic v;
        I_ARADDR <= a;
        I_ARVALID <= 1;
        do begin @(negedge I_CLOCK); v = O_ARREADY; @(posedge I_CLOCK); end while (!v);
        I_ARVALID <= 0;
        I_RREADY <= 1;
        do begin @(negedge I_CLOCK); v = O_RVALID; d = O_RDATA; r = O_RRESP; @(posedge I_CLOCK); end
        while (!v);
        I_RREADY <= 0;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        axw(a, {24'h0, d}, r);
        chk(32'(r), 32'(RESP_OKAY), "write resp");
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(d, {24'h0, e}, "read data");
        chk(32'(r), 32'(RESP_OKAY), "read resp");
    endtask
    task automatic settle();
        repeat (2) @(posedge I_CLOCK);
        @(negedge I_CLOCK);
    endtask
    // Data read: output pins show the latch, input pins the board level; readback select gives the pin level for all
    function automatic logic [7:0] exp_rd(input logic [7:0] dir, lat, od, ex, input logic rb);
        logic [7:0] oe, pin;
        oe = ~dir & ~(od & lat);
        pin = (oe & lat) | (~oe & ex);
        return ((dir | {8{rb}}) & pin) | (~dir & ~{8{rb}} & lat);
    endfunction
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] lat, dir, od, v;
        logic [11:0] cfg [5];
        int q;
        cfg = '{BASE_PULLUP, BASE_INBUF, BASE_THRESH, BASE_SLEW, BASE_ANALOG};
        d = $urandom(32'h4d66);
        repeat (4) @(posedge I_CLOCK);
        I_RESET_N <= 1;
        repeat (3) @(posedge I_CLOCK);
        for (int p = 0; p < NPORT; p++) rchk(BASE_DIR + 12'(4 * p), 8'hFF);
        rchk(BASE_PULLUP + 12'h010, 8'h01);
        @(negedge I_CLOCK);
        chk(32'(O_PULLUP_EN[32]), 32'h1, "pull-up pin 32");
        chk(O_PIN_OE[31:0] | O_PIN_OE[63:32], 32'h0, "drive after reset");
        @(posedge I_CLOCK);
        // Ports 0 and 1 in turn; port 0 feeds the pin assertions
        for (int n = 0; n < 4; n++) begin
            q = 8 * (n % 2);
            lat = (n == 0) ? 8'hFF : 8'($urandom);
            dir = (n == 0) ? 8'h00 : 8'($urandom) | 8'(n == 2);
            od = (n == 0) ? 8'h08 : 8'($urandom);
            ext <= {$urandom, $urandom};
            wreg(BASE_DATA + 12'(q / 2), lat);
            wreg(BASE_DIR + 12'(q / 2), dir);
            wreg(BASE_OUTDRV + 12'(q / 2), od);
            settle();
            chk({24'h0, O_PIN_OE[q +: 8]}, {24'h0, ~dir & ~(od & lat)}, "pin oe");
            chk({24'h0, O_PIN_OUT[q +: 8]}, {24'h0, lat & ~od}, "pin out");
            @(posedge I_CLOCK);
            rchk(BASE_DATA + 12'(q / 2), exp_rd(dir, lat, od, ext[q +: 8], 0));
            wreg(OFF_READBACK, 8'h01);
            rchk(BASE_DATA + 12'(q / 2), exp_rd(dir, lat, od, ext[q +: 8], 1));
            wreg(OFF_READBACK, 8'h00);
        end
        for (int k = 0; k < 5; k++) begin
            v = 8'($urandom) | 8'h10;
            wreg(cfg[k], v);
            settle();
            got = k == 0 ? O_PULLUP_EN : k == 1 ? O_TTL_SEL : k == 2 ? O_THRESH_SEL :
                k == 3 ? O_SLEW_SLOW : O_ANALOG_SEL;
            chk(32'(got[7:0]), 32'(v), "pin setting");
            @(posedge I_CLOCK);
        end
        wreg(OFF_CONV, 8'h01);
        settle();
        chk(32'(O_ANALOG_SEL[56]), 32'h1, "converter analog");
        @(posedge I_CLOCK);
        wreg(OFF_REDIRECT, 8'h01);
        ext[40] <= 1'h1;
        ext[8] <= 1'h0;
        settle();
        chk(32'(O_PERIPH_IN[0]), 32'h1, "redirected input");
        @(posedge I_CLOCK);
        // Low_power_state_a, stop status and redirected peripheral drive their pins
        v = 8'($urandom);
        wreg(BASE_DIR + 12'hC, 8'h00);
        wreg(BASE_DIR + 12'h10, 8'h00);
        wreg(BASE_DIR + 12'h14, 8'h00);
        wreg(OFF_LOW_POWER_STATE_A, 8'h03);
        wreg(OFF_STOP, 8'h01);
        I_LOW_POWER_STATE_A <= v[0];
        I_STOP_STATE <= v[1];
        I_PERIPH_OE <= 4'h1;
        I_PERIPH_OUT <= {3'h0, v[2]};
        settle();
        got = O_PIN_OUT;
        chk({29'h0, got[40], got[32], got[25]}, {29'h0, v[2:0]}, "status");
        got = O_PIN_OE;
        chk({29'h0, got[40], got[32], got[25]}, 32'h7, "status oe");
        @(posedge I_CLOCK);
        axw(12'h200, 32'h0, r);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
        axr(12'h042, d, r);
        chk(32'(r), 32'(RESP_SLVERR), "unaligned read");
        finish_test();
    end
endmodule
`default_nettype wire
